// File: common/refresh_sleep_pkg.sv
/*
 * Constants for the refresh/sleep configuration register and the
 * strobe and bus-state control of the octal self-refresh memory.
 * Assumes one 200 MHz core clock.
 */
package refresh_sleep_pkg;
  // register layout
  localparam int RSV_MSB   = 15;
  localparam int RSV_LSB   = 8;
  localparam int BURST_BIT = 7;
  localparam int CLK_BIT   = 6;
  localparam int SLEEP_BIT = 5;
  localparam int PAR_MSB   = 4;
  localparam int PAR_LSB   = 2;
  localparam int RI_MSB    = 1;
  localparam int RI_LSB    = 0;
  localparam logic [7:0] RSV_ONES      = 8'hFF;
  localparam logic       BURST_DEFAULT = 1'b1;
  localparam logic       CLK_DEFAULT   = 1'b1;
  localparam logic       SLEEP_DEFAULT = 1'b0;
  localparam logic [2:0] PAR_FULL      = 3'h0;
  localparam logic [2:0] PAR_NONE      = 3'h4;
  localparam logic [1:0] RI_4US        = 2'h1;
  localparam logic [1:0] RI_1US        = 2'h2;
  // timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int INTERVAL_4US_NS = 4000;
  localparam int INTERVAL_1US_NS = 1000;
  localparam int INTERVAL_4US_CYC =
    (INTERVAL_4US_NS * 1000) / CLK_PERIOD_PS;
  localparam int INTERVAL_1US_CYC =
    (INTERVAL_1US_NS * 1000) / CLK_PERIOD_PS;
  localparam int REFRESH_OP_CYC = 8;
endpackage : refresh_sleep_pkg

// File: rtl/refresh_sleep_config_and_bus_states.sv
/*
 * Refresh/sleep configuration register, self-refresh arbitration and
 * strobe/data-bus ownership during the start of each transaction.
 * Assumes a transaction decoder on ref_clk reports the phases and
 * register writes; pins arrive asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
// How it works
// - bit 7 one gives linear bursts (default), zero gives wrapped.
// - bit 6 one gives single-ended clock (default), zero differential.
// - single-ended mode ignores the complementary clock input entirely.
// - writing one to bit 5 enters hybrid sleep; resets to zero.
// - falling chip select in sleep exits and clears bit 5.
// - power-on or hardware reset ends sleep and disables refresh.
// - bits 4:2 restrict self-refresh region; 100 means no refresh.
// - bits 1:0 read-only interval code, 01 is 4 us, 10 is 1 us.
// - refresh starts only when no read or write is active.
// - access starting before refresh completes drives strobe high in CA.
// - read latency keeps data high-Z and strobe driven low.
// - write latency leaves data and strobe undriven by both ends.
// - strobe driven every CA; zero-latency writes then release it.
// - zero-latency writes use no mask; every byte is written.
// - strobe high in CA means two initial latency periods.
module refresh_sleep_config_and_bus_states
  import refresh_sleep_pkg::*;
#(
  parameter bit HOT_GRADE   = 1'b0,
  parameter int REFRESH_CYC = refresh_sleep_pkg::REFRESH_OP_CYC
)(
  // core clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // memory pins (asynchronous)
  input  wire logic        chipSelectN,
  input  wire logic        hwResetN,
  input  wire logic        linkClk,
  input  wire logic        clock_complement,
  input  wire logic        rwdsIn,
  // strobe and data bus control
  output logic             rwdsOut,
  output logic             rwdsOe,
  output logic             dqRelease,
  // transaction phases from the decoder
  input  wire logic        command_address_phase,
  input  wire logic        readLatency,
  input  wire logic        writeLatency,
  input  wire logic        zeroLatWrite,
  input  wire logic        accessActive,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWdata,
  // status and configuration out
  output logic [15:0]      refresh_sleep_config,
  output logic             linkEdge,
  output logic             byteMask,
  output logic             hybrid_sleep,
  output logic             refreshBusy,
  output logic             twoLatency
);
  import refresh_sleep_pkg::*;

  localparam int INTERVAL_CYC =
    HOT_GRADE ? INTERVAL_1US_CYC : INTERVAL_4US_CYC;
  localparam logic [1:0] RI_CODE = HOT_GRADE ? RI_1US : RI_4US;
  localparam int CW = $clog2(INTERVAL_4US_CYC + 1);

  // refresh must fit the counter and the shorter interval
  if (REFRESH_CYC < 1 || REFRESH_CYC >= INTERVAL_1US_CYC)
  begin : g_bad_refresh
    $error("REFRESH_CYC out of range");
  end

  // two-flop synchronisers for pins
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  always_ff @(posedge ref_clk) begin
    syncA_reg <= {rwdsIn, clock_complement, linkClk, hwResetN,
                  chipSelectN};
    syncB_reg <= syncA_reg;
  end
  wire csN  = syncB_reg[0];
  wire hwRn = syncB_reg[1];
  wire ckT  = syncB_reg[2];
  wire ckC  = syncB_reg[3];
  wire rwdsS = syncB_reg[4];

  logic csPrev_reg;
  logic ckPrev_reg;
  logic burstLin_reg;
  logic clkSingle_reg;
  logic sleep_reg;
  logic [2:0] region_reg;
  logic refreshOn_reg;
  logic [CW-1:0] interval_reg;
  logic pending_reg;
  logic [7:0] opCnt_reg;
  logic extra_reg;

  wire csFall = csPrev_reg & ~csN;
  wire anyReset = sys_rst | ~hwRn;

  wire ckLevel = clkSingle_reg ? ckT : (ckT & ~ckC);

  always_ff @(posedge ref_clk) begin
    csPrev_reg <= anyReset ? 1'b1 : csN;
    ckPrev_reg <= anyReset ? 1'b0 : ckLevel;
    linkEdge   <= anyReset ? 1'b0 : (ckLevel & ~ckPrev_reg);
  end

  // configuration fields
  always_ff @(posedge ref_clk) begin
    if (anyReset)
    begin
      burstLin_reg  <= BURST_DEFAULT;
      clkSingle_reg <= CLK_DEFAULT;
      region_reg    <= PAR_FULL;
    end
    else if (regWrite)
    begin
      burstLin_reg  <= regWdata[BURST_BIT];
      clkSingle_reg <= regWdata[CLK_BIT];
      region_reg    <= regWdata[PAR_MSB:PAR_LSB];
    end
  end

  // hybrid sleep: write sets, chip select fall clears, set wins
  always_ff @(posedge ref_clk) begin
    if (anyReset)
      sleep_reg <= SLEEP_DEFAULT;
    else if (regWrite && regWdata[SLEEP_BIT])
      sleep_reg <= 1'b1;
    else if (csFall)
      sleep_reg <= 1'b0;
  end

  // refresh off after reset until next selection
  always_ff @(posedge ref_clk) begin
    if (anyReset)
      refreshOn_reg <= 1'b0;
    else if (csFall)
      refreshOn_reg <= 1'b1;
  end

  // refresh interval timer and request
  wire intervalDone = (interval_reg == CW'(INTERVAL_CYC - 1));
  wire regionOn = refreshOn_reg && (region_reg != PAR_NONE);
  wire opRunning = (opCnt_reg != 8'h00);
  wire opStart = pending_reg && !accessActive && !opRunning;

  always_ff @(posedge ref_clk) begin
    if (anyReset || intervalDone)
      interval_reg <= '0;
    else
      interval_reg <= interval_reg + CW'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (anyReset)
      pending_reg <= 1'b0;
    else if (intervalDone && regionOn)
      pending_reg <= 1'b1;
    else if (opStart)
      pending_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (anyReset)
      opCnt_reg <= 8'h00;
    else if (opStart)
      opCnt_reg <= 8'(REFRESH_CYC);
    else if (opRunning)
      opCnt_reg <= opCnt_reg - 8'h01;
  end

  // latch refresh clash at access start
  always_ff @(posedge ref_clk) begin
    if (anyReset || csN)
      extra_reg <= 1'b0;
    else if (csFall)
      extra_reg <= pending_reg | opRunning;
  end

  // strobe and data ownership per interface state
  wire rwdsDrive = !csN && (command_address_phase || readLatency);
  // strobe reports latency in every CA
  wire rwdsLevel = command_address_phase ? extra_reg : 1'b0;
  wire dqFree = csN || command_address_phase || readLatency ||
                writeLatency;
  wire maskNow = !csN && !zeroLatWrite && rwdsS;

  always_ff @(posedge ref_clk) begin
    if (anyReset)
    begin
      rwdsOe    <= 1'b0;
      rwdsOut   <= 1'b0;
      dqRelease <= 1'b1;
      byteMask  <= 1'b0;
    end
    else
    begin
      rwdsOe    <= rwdsDrive;
      rwdsOut   <= rwdsDrive & rwdsLevel;
      dqRelease <= dqFree;
      byteMask  <= maskNow;
    end
  end

  // status outputs and read-back image
  always_ff @(posedge ref_clk) begin
    if (anyReset)
    begin
      hybrid_sleep <= SLEEP_DEFAULT;
      refreshBusy  <= 1'b0;
      twoLatency   <= 1'b0;
      refresh_sleep_config <= {RSV_ONES, BURST_DEFAULT, CLK_DEFAULT,
                               SLEEP_DEFAULT, PAR_FULL, RI_CODE};
    end
    else
    begin
      hybrid_sleep <= sleep_reg;
      refreshBusy  <= opRunning;
      twoLatency   <= extra_reg;
      refresh_sleep_config <= {RSV_ONES, burstLin_reg, clkSingle_reg,
                               sleep_reg, region_reg, RI_CODE};
    end
  end
endmodule : refresh_sleep_config_and_bus_states

// File: testbench/host_ctrl_model.sv
/*
 * Host controller pin model: chip select and the link clock pair.
 * Assumes the bench raises selectReq for each frame, core-clock paced.
 */
`timescale 1ns/1ps
module host_ctrl_model (
  // frame request and complement tie-off
  input  wire logic selectReq,
  input  wire logic compTied,
  // memory pins
  output logic      chipSelectN,
  output logic      linkClk,
  output logic      clock_complement
);
  logic clkState = 1'b0;
  assign chipSelectN = ~selectReq;
  always #24 clkState = chipSelectN ? 1'b0 : ~clkState;
  assign linkClk = clkState;
  // tied high or driven, never floating
  assign clock_complement = compTied ? 1'b1 : ~clkState;
endmodule : host_ctrl_model

// File: testbench/refresh_sleep_config_and_bus_states_bench.sv
/*
 * Bench for the refresh/sleep register and strobe control.
 * Assumes the host model, the checker and the package are compiled.
 */
`timescale 1ns/1ps
module refresh_sleep_config_and_bus_states_bench;
  import refresh_sleep_pkg::*;
  logic ref_clk = 0, sys_rst = 1, selectReq = 0, regWrite = 0;
  logic caPh = 0, rdPh = 0, wrPh = 0, zlPh = 0, accessActive = 0;
  logic [15:0] regWdata = 16'h0000, cfg;
  logic rwdsOut, rwdsOe, dqRelease, byteMask, sleepBit, busy;
  logic hwRstN = 1, rwdsPin = 0, compTied = 1, lnkEdge, twoLat;
  wire chipSelectN, linkClk, clock_complement;
  int n_mismatch = 0, checks_done = 0, cyc = 0, busyCnt = 0;
  int edgeCnt = 0, pinCnt = 0;
  always #2.5 ref_clk = ~ref_clk;
  host_ctrl_model host (.selectReq(selectReq), .compTied(compTied),
    .chipSelectN(chipSelectN), .linkClk(linkClk),
    .clock_complement(clock_complement));
  refresh_sleep_config_and_bus_states #(.HOT_GRADE(1'b0), .REFRESH_CYC(8))
  dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .hwResetN(hwRstN), .linkClk(linkClk),
    .clock_complement(clock_complement),
    .rwdsIn(rwdsPin), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe),
    .dqRelease(dqRelease),
    .command_address_phase(caPh), .readLatency(rdPh), .writeLatency(wrPh),
    .zeroLatWrite(zlPh), .accessActive(accessActive), .regWrite(regWrite),
    .regWdata(regWdata), .refresh_sleep_config(cfg), .linkEdge(lnkEdge),
    .byteMask(byteMask), .hybrid_sleep(sleepBit), .refreshBusy(busy),
    .twoLatency(twoLat));
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task wr(input logic [15:0] v);
    regWrite = 1;
    regWdata = v;
    tick(1);
    regWrite = 0;
    tick(2);
  endtask : wr
  // one frame: CA, then a latency phase of the given kind
  task frame(input int kind, input logic [2:0] exp);
    selectReq = 1;
    tick(6);
    caPh = 1;
    tick(5);
    chk({15'h0, rwdsOe}, 16'h0001);
    caPh = 0;
    rdPh = (kind == 0);
    wrPh = (kind == 1);
    zlPh = (kind == 2);
    tick(5);
    chk({13'h0, rwdsOe, dqRelease, byteMask}, {13'h0, exp});
    rdPh = 0;
    wrPh = 0;
    rwdsPin = (kind == 1);
    tick(5);
    chk({14'h0, dqRelease, byteMask}, {14'h0, 1'b0, kind == 1});
    {rdPh, wrPh, zlPh} = 3'h0;
    rwdsPin = 0;
    selectReq = 0;
    tick(6);
  endtask : frame
  // one frame: CA strobe level and doubled latency flag
  task lat(input logic exp);
    selectReq = 1;
    tick(6);
    caPh = 1;
    tick(5);
    chk({14'h0, rwdsOut, twoLat}, {14'h0, exp, exp});
    caPh = 0;
    selectReq = 0;
    tick(6);
  endtask : lat
  always @(negedge ref_clk)
  begin
    if (busy === 1'b1)
      busyCnt++;
    if (lnkEdge === 1'b1)
      edgeCnt++;
  end
  always @(posedge linkClk)
    pinCnt++;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial
  begin
    tick(6);
    sys_rst = 0;
    tick(3);
    chk(cfg, 16'hFFC1);
    for (int i = 0; i < 8; i++)
    begin
      wr({8'hFF, i[1:0], 1'b0, i[2:0], 2'h3});
      chk(cfg, {8'hFF, i[1:0], 1'b0, i[2:0], 2'h1});
    end
    wr(16'hFFC1);
    frame(0, 3'h6);
    frame(1, 3'h2);
    frame(2, 3'h0);
    wr(16'hFFE1);
    chk({15'h0, sleepBit}, 16'h0001);
    selectReq = 1;
    tick(20);
    selectReq = 0;
    tick(8);
    chk(cfg, 16'hFFC1);
    tick(20000);
    accessActive = 1;
    tick(10);
    busyCnt = 0;
    tick(1000);
    chk(busyCnt[15:0], 16'h0000);
    accessActive = 0;
    busyCnt = 0;
    tick(1000);
    chk({15'h0, busyCnt != 0}, 16'h0001);
    wr(16'hFFD1);
    tick(20);
    busyCnt = 0;
    tick(1700);
    chk(busyCnt[15:0], 16'h0000);
    wr(16'hFFE1);
    hwRstN = 0;
    tick(4);
    hwRstN = 1;
    tick(4);
    chk(cfg, 16'hFFC1);
    busyCnt = 0;
    tick(1700);
    chk(busyCnt[15:0], 16'h0000);
    lat(1'b0);
    accessActive = 1;
    tick(1700);
    lat(1'b1);
    accessActive = 0;
    chk(edgeCnt[15:0], pinCnt[15:0]);
    end_of_test;
  end
endmodule : refresh_sleep_config_and_bus_states_bench
bind refresh_sleep_config_and_bus_states
  refresh_sleep_props #(.HOT_GRADE(HOT_GRADE)) props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .command_address_phase(command_address_phase),
    .readLatency(readLatency), .writeLatency(writeLatency),
    .zeroLatWrite(zeroLatWrite), .accessActive(accessActive),
    .regWrite(regWrite), .regWdata(regWdata),
    .refresh_sleep_config(refresh_sleep_config), .rwdsOut(rwdsOut),
    .rwdsOe(rwdsOe), .dqRelease(dqRelease), .byteMask(byteMask),
    .hybrid_sleep(hybrid_sleep), .refreshBusy(refreshBusy),
    .twoLatency(twoLatency));

// File: testbench/refresh_sleep_props.sv
/*
 * Checker for the refresh/sleep register and the strobe ownership.
 * Sees only the top ports; bound from the bench, disabled by sys_rst only, not by hwResetN.
 */
`timescale 1ns/1ps
module refresh_sleep_props
  import refresh_sleep_pkg::*;
#(parameter bit HOT_GRADE = 1'b0)(
  // clock, reset, select pin
  input wire logic        ref_clk, sys_rst, chipSelectN,
  // phases and register write
  input wire logic        command_address_phase, readLatency,
  input wire logic        writeLatency, zeroLatWrite, accessActive,
  input wire logic        regWrite,
  input wire logic [15:0] regWdata, refresh_sleep_config,
  // strobe and status
  input wire logic        rwdsOut, rwdsOe, dqRelease, byteMask,
  input wire logic        hybrid_sleep, refreshBusy, twoLatency
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rsv_ones: assert property (
    refresh_sleep_config[15:8] == RSV_ONES)
    else $error("reserved byte not ones");
  a_interval_ro: assert property (
    refresh_sleep_config[1:0] == (HOT_GRADE ? RI_1US : RI_4US))
    else $error("interval code wrong");
  a_mode_bits: assert property (
    regWrite |-> ##2
    refresh_sleep_config[7:6] == $past(regWdata[7:6], 2))
    else $error("burst or clock bit not written");
  a_par_field: assert property (
    regWrite |-> ##2
    refresh_sleep_config[4:2] == $past(regWdata[4:2], 2))
    else $error("refresh region not written");
  a_sleep_exit: assert property (
    hybrid_sleep && $fell(chipSelectN) |-> ##[1:6] !hybrid_sleep)
    else $error("sleep not left");
  a_ca_strobe: assert property (
    (!chipSelectN && command_address_phase)[*4]
    |-> rwdsOe && rwdsOut == twoLatency)
    else $error("strobe in CA");
  a_read_lat: assert property (
    (!chipSelectN && readLatency)[*4]
    |-> rwdsOe && !rwdsOut && dqRelease)
    else $error("read latency");
  a_write_turn: assert property (
    (!chipSelectN && writeLatency)[*4]
    |-> !rwdsOe && dqRelease)
    else $error("write turnaround");
  a_zero_write: assert property (
    (!chipSelectN && zeroLatWrite)[*4]
    |-> !rwdsOe && !dqRelease && !byteMask)
    else $error("zero latency");
  a_refresh_idle: assert property (
    $rose(refreshBusy) |-> !$past(accessActive, 2))
    else $error("refresh during access");
endmodule : refresh_sleep_props
